// ==== verilog/vjd_top.sv ====
// Vector jump islanding detector: settings, jump evaluation,
// trip gating, event flags and register port.
// Assumes the front end drives meas and meas_valid on mclk.
`timescale 1ns/100ps
`include "vjd_cfg.svh"
module vjd_top #(
    parameter int CYC_PER_MS = `VJD_CYC_PER_MS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic meas_valid,
    input wire vjd_pkg::vjd_meas_type meas,
    input wire logic [15:0] unom,
    input wire logic undervolt,
    output logic start,
    output logic trip,
    output logic irq
);
    vjd_pkg::vjd_set_type set_q, set_d;
    logic [`VJD_EVT_W-1:0] mask_q, mask_d;
    logic [`VJD_EVT_W-1:0] evt_q, evt_d, evt_set;
    logic [15:0] prev_angle_q, prev_angle_d;
    logic prev_valid_q, prev_valid_d;
    logic start_d, irq_d;
    logic [15:0] rdata_d;
    logic uv_s1_q, uv_s2_q;
    logic over, upos_ok, neg_blk, zero_blk;
    logic jump_hit, fire, abort;
    logic [31:0] hc_q;

    // Settings and mask written by software, clamped to range
    always_comb begin
        set_d = set_q;
        mask_d = mask_q;
        if (wr) begin
            case (addr)
                `VJD_ADDR_CTRL: begin
                    set_d.enable = wdata[`VJD_CTRL_EN_BIT];
                end
                `VJD_ADDR_PHLIM: begin
                    set_d.ph_lim = 5'(vjd_pkg::vjd_clamp(wdata,
                        `VJD_PHLIM_MIN, `VJD_PHLIM_MAX));
                end
                `VJD_ADDR_UPOS: begin
                    set_d.upos_pct = 7'(vjd_pkg::vjd_clamp(wdata,
                        `VJD_UPOS_MIN, `VJD_UPOS_MAX));
                end
                `VJD_ADDR_UNEG: begin
                    set_d.uneg_pct = 7'(vjd_pkg::vjd_clamp(wdata,
                        `VJD_UNEG_MIN, `VJD_UNEG_MAX));
                end
                `VJD_ADDR_UZERO: begin
                    set_d.uzero_pct = 7'(vjd_pkg::vjd_clamp(wdata,
                        `VJD_UZERO_MIN, `VJD_UZERO_MAX));
                end
                `VJD_ADDR_PULSE: begin
                    set_d.pulse_ms = 9'(vjd_pkg::vjd_clamp(wdata,
                        `VJD_PULSE_MIN, `VJD_PULSE_MAX));
                end
                `VJD_ADDR_MASK: begin
                    mask_d = wdata[`VJD_EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Setting registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            set_q.enable <= `VJD_RST_EN;
            set_q.ph_lim <= `VJD_RST_PHLIM;
            set_q.upos_pct <= `VJD_RST_UPOS;
            set_q.uneg_pct <= `VJD_RST_UNEG;
            set_q.uzero_pct <= `VJD_RST_UZERO;
            set_q.pulse_ms <= `VJD_RST_PULSE;
            mask_q <= `VJD_RST_MASK;
        end else if (ce) begin
            set_q <= set_d;
            mask_q <= mask_d;
        end
    end

    // Undervoltage input comes from outside: two-stage synchroniser
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            uv_s1_q <= 1'b0;
            uv_s2_q <= 1'b0;
        end else if (ce) begin
            uv_s1_q <= undervolt;
            uv_s2_q <= uv_s1_q;
        end
    end

    // Compensated angle jump against the stored angle
    vjd_jump_calc u_jump (
        .cur(meas.angle),
        .prev(prev_angle_q),
        .rot(meas.rot),
        .lim_deg(set_q.ph_lim),
        .over(over)
    );

    // Sequence voltage checks relative to nominal
    assign upos_ok = vjd_pkg::vjd_pct_above(meas.upos,
        set_q.upos_pct, unom);
    assign neg_blk = vjd_pkg::vjd_pct_above(meas.uneg,
        set_q.uneg_pct, unom);
    assign zero_blk = vjd_pkg::vjd_pct_above(meas.uzero,
        set_q.uzero_pct, unom);

    // Start and trip decisions on each new measurement
    assign jump_hit = meas_valid && set_q.enable && prev_valid_q
        && over;
    assign fire = jump_hit && upos_ok && !neg_blk && !zero_blk
        && !uv_s2_q && !trip;
    assign abort = !set_q.enable || uv_s2_q;

    // Trip pulse, runs its length unless disabled or undervoltage
    vjd_pulse_timer #(
        .CYC_PER_MS(CYC_PER_MS),
        .MS_W(9)
    ) u_timer (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .go(fire),
        .abort(abort),
        .len_ms(set_q.pulse_ms),
        .busy(trip)
    );

    // Angle history and start level
    always_comb begin
        prev_angle_d = meas_valid ? meas.angle : prev_angle_q;
        prev_valid_d = set_q.enable && (prev_valid_q || meas_valid);
        if (!set_q.enable) begin
            start_d = 1'b0;
        end else if (meas_valid) begin
            start_d = jump_hit;
        end else begin
            start_d = start_q_hold();
        end
    end

    function automatic logic start_q_hold();
        return start;
    endfunction

    // Evaluation registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_angle_q <= 16'h0000;
            prev_valid_q <= 1'b0;
            start <= 1'b0;
        end else if (ce) begin
            prev_angle_q <= prev_angle_d;
            prev_valid_q <= prev_valid_d;
            start <= start_d;
        end
    end

    // Sticky events, cleared by reading them; a new event wins
    always_comb begin
        evt_set = {jump_hit && (neg_blk || zero_blk), fire,
            jump_hit && !start};
        if (rd && addr == `VJD_ADDR_EVT) begin
            evt_d = evt_set;
        end else begin
            evt_d = evt_q | evt_set;
        end
        irq_d = |(evt_d & mask_d);
        rdata_d = 16'h0000;
        if (rd) begin
            case (addr)
                `VJD_ADDR_CTRL: rdata_d = {15'h0000, set_q.enable};
                `VJD_ADDR_PHLIM: rdata_d = {11'h000, set_q.ph_lim};
                `VJD_ADDR_UPOS: rdata_d = {9'h000, set_q.upos_pct};
                `VJD_ADDR_UNEG: rdata_d = {9'h000, set_q.uneg_pct};
                `VJD_ADDR_UZERO: rdata_d = {9'h000, set_q.uzero_pct};
                `VJD_ADDR_PULSE: rdata_d = {7'h00, set_q.pulse_ms};
                `VJD_ADDR_STAT: begin
                    rdata_d = {10'h000, uv_s2_q, zero_blk, neg_blk,
                        upos_ok, trip, start};
                end
                `VJD_ADDR_EVT: rdata_d = {13'h0000, evt_q};
                `VJD_ADDR_MASK: rdata_d = {13'h0000, mask_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Event, interrupt and read data registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            evt_q <= '0;
            irq <= 1'b0;
            rdata <= 16'h0000;
        end else if (ce) begin
            evt_q <= evt_d;
            irq <= irq_d;
            rdata <= rdata_d;
        end
    end

    // Counts cycles of the trip pulse for checking
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hc_q <= 32'h00000000;
        end else if (ce) begin
            hc_q <= trip ? 32'(hc_q + 1'b1) : 32'h00000000;
        end
    end

    default clocking vjd_cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    AST_OFF_SILENT: assert property (
        (ce && !set_q.enable) |=> (!start && !trip))
        else $error("start or trip while detector off");

    AST_START_ON_JUMP: assert property (
        (ce && jump_hit) |=> start)
        else $error("jump over limit gave no start");

    AST_TRIP_NEEDS_UPOS: assert property (
        $rose(trip) |-> $past(upos_ok))
        else $error("trip with low positive-sequence voltage");

    AST_TRIP_NEG_BLOCK: assert property (
        $rose(trip) |-> !$past(neg_blk))
        else $error("trip despite negative-sequence block");

    AST_TRIP_ZERO_BLOCK: assert property (
        $rose(trip) |-> !$past(zero_blk))
        else $error("trip despite zero-sequence block");

    AST_UV_NO_TRIP: assert property (
        (ce && uv_s2_q) |=> !trip)
        else $error("trip while undervoltage asserted");

    AST_PREV_ANGLE: assert property (
        (ce && meas_valid && set_q.enable) |=>
            (prev_valid_q && prev_angle_q == $past(meas.angle)))
        else $error("previous angle not stored");

    AST_DRIFT_ONLY: assert property (
        (ce && meas_valid && set_q.enable && prev_valid_q
            && meas.angle == 16'(prev_angle_q + meas.rot))
        |=> !start)
        else $error("pure frequency drift gave a start");

    AST_PULSE_LEN: assert property (
        ($fell(trip) && !$past(abort) && $stable(set_q.pulse_ms)) |->
            hc_q == 32'(set_q.pulse_ms) * 32'(CYC_PER_MS))
        else $error("trip pulse length wrong");

    AST_TRIP_GO: assert property (
        (ce && fire) |=> trip ##1 (trip || $past(abort) || !ce))
        else $error("permitted trip did not start");

    AST_IRQ_LEVEL: assert property (
        irq == |(evt_q & mask_q))
        else $error("interrupt level disagrees with flags");
endmodule

// ==== verilog/vjd_cfg.svh ====
// Constants of the vector jump islanding detector: offsets, fields,
// reset values, setting ranges and timing counts.
// Assumes one 100 MHz clock and a 4-bit register address.
//
// How it works
// - Enable setting Off by default, silences start and trip
// - Start when compensated jump exceeds limit
// - Trip needs positive-sequence voltage above minimum
// - Negative-sequence above limit blocks trip
// - Zero-sequence above limit blocks trip
// - Undervoltage input asserted means no trip
// - Compare present angle with previous measurement
// - Subtract frequency-deviation rotation before comparing
// - Trip pulse 150 to 500 ms long
`ifndef VJD_CFG_SVH
`define VJD_CFG_SVH

// Register offsets
`define VJD_ADDR_CTRL 4'h0
`define VJD_ADDR_PHLIM 4'h1
`define VJD_ADDR_UPOS 4'h2
`define VJD_ADDR_UNEG 4'h3
`define VJD_ADDR_UZERO 4'h4
`define VJD_ADDR_PULSE 4'h5
`define VJD_ADDR_STAT 4'h6
`define VJD_ADDR_EVT 4'h7
`define VJD_ADDR_MASK 4'h8

// Field positions
`define VJD_CTRL_EN_BIT 0
`define VJD_EVT_W 3

// Reset values of the settings
`define VJD_RST_EN 1'h0
`define VJD_RST_PHLIM 5'h0A
`define VJD_RST_UPOS 7'h1E
`define VJD_RST_UNEG 7'h0A
`define VJD_RST_UZERO 7'h05
`define VJD_RST_PULSE 9'h096
`define VJD_RST_MASK 3'h0

// Setting ranges
`define VJD_PHLIM_MIN 16'h0005
`define VJD_PHLIM_MAX 16'h0019
`define VJD_UPOS_MIN 16'h000A
`define VJD_UPOS_MAX 16'h0064
`define VJD_UNEG_MIN 16'h0005
`define VJD_UNEG_MAX 16'h0032
`define VJD_UZERO_MIN 16'h0001
`define VJD_UZERO_MAX 16'h001E
`define VJD_PULSE_MIN 16'h0096
`define VJD_PULSE_MAX 16'h01F4

// Timing
`define VJD_CLK_PERIOD_NS 10
`define VJD_MS_IN_NS 1000000
`define VJD_CYC_PER_MS (`VJD_MS_IN_NS / `VJD_CLK_PERIOD_NS)

`endif

// ==== verilog/vjd_pkg.sv ====
// Types and shared arithmetic of the vector jump islanding detector.
// Assumes voltages of one measurement share the unit of the nominal.
package vjd_pkg;

    // One measurement set from the phasor front end
    typedef struct packed {
        logic [15:0] angle;
        logic [15:0] rot;
        logic [15:0] upos;
        logic [15:0] uneg;
        logic [15:0] uzero;
    } vjd_meas_type;

    // Software settings
    typedef struct packed {
        logic enable;
        logic [4:0] ph_lim;
        logic [6:0] upos_pct;
        logic [6:0] uneg_pct;
        logic [6:0] uzero_pct;
        logic [8:0] pulse_ms;
    } vjd_set_type;

    // Trip pulse timer states
    typedef enum logic {
        VJD_T_IDLE = 1'b0,
        VJD_T_RUN = 1'b1
    } vjd_tstate_type;

    // Voltage above pct percent of nominal
    function automatic logic vjd_pct_above(logic [15:0] u,
            logic [6:0] pct, logic [15:0] unom);
        logic [22:0] lhs;
        logic [22:0] rhs;
        lhs = {7'h00, u} * 23'h000064;
        rhs = {16'h0000, pct} * {7'h00, unom};
        return lhs > rhs;
    endfunction

    // Hold a written value inside its range
    function automatic logic [15:0] vjd_clamp(logic [15:0] v,
            logic [15:0] lo, logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

endpackage

// ==== verilog/vjd_jump_calc.sv ====
// Compensated angle jump compare, purely combinational.
// Assumes angles in units of 360/65536 degree, wrapping.
`timescale 1ns/100ps
module vjd_jump_calc (
    input wire logic [15:0] cur,
    input wire logic [15:0] prev,
    input wire logic [15:0] rot,
    input wire logic [4:0] lim_deg,
    output logic over
);
    logic [15:0] diff;
    logic [15:0] mag;
    logic [24:0] lhs;
    logic [24:0] rhs;

    // Present minus previous minus drift, then magnitude
    assign diff = 16'(cur - prev - rot);
    assign mag = diff[15] ? 16'(-diff) : diff;
    // Compare in degrees without a divider
    assign lhs = 25'(mag) * 25'h0000168;
    assign rhs = {4'h0, lim_deg, 16'h0000};
    assign over = lhs > rhs;
endmodule

// ==== verilog/vjd_pulse_timer.sv ====
// Trip pulse timer: counts whole milliseconds of the clock.
// Assumes go only while idle; abort ends a pulse at once.
`timescale 1ns/100ps
module vjd_pulse_timer #(
    parameter int CYC_PER_MS = 100000,
    parameter int MS_W = 9
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic go,
    input wire logic abort,
    input wire logic [MS_W-1:0] len_ms,
    output logic busy
);
    localparam int PW = $clog2(CYC_PER_MS);
    vjd_pkg::vjd_tstate_type state_q, state_d;
    logic [PW-1:0] pre_q, pre_d;
    logic [MS_W-1:0] ms_q, ms_d;
    logic [MS_W-1:0] len_q, len_d;
    logic busy_d;

    // Next state, length latched at start
    always_comb begin
        state_d = state_q;
        pre_d = pre_q;
        ms_d = ms_q;
        len_d = len_q;
        case (state_q)
            vjd_pkg::VJD_T_IDLE: begin
                if (go && !abort) begin
                    state_d = vjd_pkg::VJD_T_RUN;
                    pre_d = '0;
                    ms_d = '0;
                    len_d = len_ms;
                end
            end
            vjd_pkg::VJD_T_RUN: begin
                if (abort) begin
                    state_d = vjd_pkg::VJD_T_IDLE;
                end else if (pre_q == PW'(CYC_PER_MS - 1)) begin
                    pre_d = '0;
                    if (ms_q == MS_W'(len_q - 1'b1)) begin
                        state_d = vjd_pkg::VJD_T_IDLE;
                    end else begin
                        ms_d = MS_W'(ms_q + 1'b1);
                    end
                end else begin
                    pre_d = PW'(pre_q + 1'b1);
                end
            end
            default: state_d = vjd_pkg::VJD_T_IDLE;
        endcase
        busy_d = state_d == vjd_pkg::VJD_T_RUN;
    end

    // Timer registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= vjd_pkg::VJD_T_IDLE;
            pre_q <= '0;
            ms_q <= '0;
            len_q <= '0;
            busy <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            pre_q <= pre_d;
            ms_q <= ms_d;
            len_q <= len_d;
            busy <= busy_d;
        end
    end
endmodule

// ==== bench/vjd_frontend.sv ====
// Behavioural phasor and frequency front end for the detector bench.
// Assumes the bench calls send once per evaluation, on mclk.
`timescale 1ns/100ps
module vjd_frontend (
    input wire logic mclk,
    output logic meas_valid,
    output vjd_pkg::vjd_meas_type meas
);
    // Idle link at time zero
    initial begin
        meas_valid = 1'h0;
        meas = '0;
    end

    // One set a cycle; afterwards the bus shows garbage, not old data
    task automatic send(input vjd_pkg::vjd_meas_type m);
        @(posedge mclk);
        meas_valid <= 1'h1;
        meas <= m;
        @(posedge mclk);
        meas_valid <= 1'h0;
        meas <= ~m;
    endtask
endmodule

// ==== bench/vjd_top_bench.sv ====
// Self-checking bench of the vector jump islanding detector.
// Assumes the front end model and a 100 MHz clock; pulses shortened.
`timescale 1ns/100ps
module vjd_top_bench;
    localparam int CYC = 10;
    localparam logic [15:0] BASE = 16'h1000;
    typedef struct packed {
        logic [15:0] diff;
        logic [15:0] rot;
        logic [15:0] upos;
        logic [15:0] uneg;
        logic [15:0] uzero;
        logic uv;
        logic st;
        logic tr;
    } vjd_row_type;
    // Jump 12 deg = 0889, 8 deg = 05B0; unom 1000, limits 300/100/50
    vjd_row_type rows [0:12] = '{
        '{16'h0889, 16'h0000, 16'h01F4, 16'h0000, 16'h0000, 1'h0, 1'h1, 1'h1},
        '{16'h05B0, 16'h0000, 16'h01F4, 16'h0000, 16'h0000, 1'h0, 1'h0, 1'h0},
        '{16'hF777, 16'h0000, 16'h01F4, 16'h0000, 16'h0000, 1'h0, 1'h1, 1'h1},
        '{16'h0C71, 16'h03E8, 16'h01F4, 16'h0000, 16'h0000, 1'h0, 1'h1, 1'h1},
        '{16'h04B0, 16'hFC18, 16'h01F4, 16'h0000, 16'h0000, 1'h0, 1'h1, 1'h1},
        '{16'h0A28, 16'h03E8, 16'h01F4, 16'h0000, 16'h0000, 1'h0, 1'h0, 1'h0},
        '{16'h0889, 16'h0000, 16'h00FA, 16'h0000, 16'h0000, 1'h0, 1'h1, 1'h0},
        '{16'h0889, 16'h0000, 16'h012C, 16'h0000, 16'h0000, 1'h0, 1'h1, 1'h0},
        '{16'h0889, 16'h0000, 16'h01F4, 16'h0065, 16'h0000, 1'h0, 1'h1, 1'h0},
        '{16'h0889, 16'h0000, 16'h01F4, 16'h0064, 16'h0000, 1'h0, 1'h1, 1'h1},
        '{16'h0889, 16'h0000, 16'h01F4, 16'h0000, 16'h0033, 1'h0, 1'h1, 1'h0},
        '{16'h0889, 16'h0000, 16'h01F4, 16'h0000, 16'h0032, 1'h0, 1'h1, 1'h1},
        '{16'h0889, 16'h0000, 16'h01F4, 16'h0000, 16'h0000, 1'h1, 1'h1, 1'h0}
    };
    logic [15:0] rst_exp [0:9] = '{16'h0000, 16'h000A, 16'h001E, 16'h000A,
        16'h0005, 16'h0096, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic mclk;
    logic rst;
    logic ce;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic meas_valid;
    vjd_pkg::vjd_meas_type meas;
    logic undervolt;
    logic start;
    logic trip;
    logic irq;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    int t0;
    logic [15:0] d;

    vjd_frontend fe (.mclk(mclk), .meas_valid(meas_valid), .meas(meas));
    vjd_top #(.CYC_PER_MS(CYC)) dut (.mclk(mclk), .rst(rst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .meas_valid(meas_valid), .meas(meas), .unom(16'h03E8),
        .undervolt(undervolt), .start(start), .trip(trip), .irq(irq));

    // Clock
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    // Compare and count
    task automatic check(input string name, input logic [15:0] seen,
            input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Register bus cycles
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        v = rdata;
    endtask

    // History fill, then the jumped set
    task automatic pair(input vjd_row_type r);
        fe.send('{BASE, r.rot, r.upos, r.uneg, r.uzero});
        fe.send('{BASE + r.diff, r.rot, r.upos, r.uneg, r.uzero});
        @(posedge mclk);
        #1;
    endtask

    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        rst = 1'h1;
        ce = 1'h1;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'h0;
        rd = 1'h0;
        undervolt = 1'h0;
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        #1;
        check("start", start, 16'h0000);
        check("trip", trip, 16'h0000);
        check("irq", irq, 16'h0000);
        for (int a = 0; a < 10; a++) begin
            if (a != 6) begin
                rd_reg(a[3:0], d);
                check("reset value", d, rst_exp[a]);
            end
        end
        // Out-of-range writes land on the range ends
        wr_reg(4'h1, 16'h001E);
        rd_reg(4'h1, d);
        check("phase limit", d, 16'h0019);
        wr_reg(4'h2, 16'h0005);
        rd_reg(4'h2, d);
        check("upos limit", d, 16'h000A);
        wr_reg(4'h5, 16'h0064);
        rd_reg(4'h5, d);
        check("pulse length", d, 16'h0096);
        wr_reg(4'h1, 16'h000A);
        wr_reg(4'h2, 16'h001E);
        // Disabled detector ignores a jump
        pair(rows[0]);
        check("start off", start, 16'h0000);
        check("trip off", trip, 16'h0000);
        // Table of jump, compensation and blocking cases
        foreach (rows[i]) begin
            undervolt <= rows[i].uv;
            wr_reg(4'h0, 16'h0001);
            pair(rows[i]);
            check("start", start, rows[i].st);
            check("trip", trip, rows[i].tr);
            wr_reg(4'h0, 16'h0000);
            repeat (3) @(posedge mclk);
            #1;
            check("trip disabled", trip, 16'h0000);
        end
        undervolt <= 1'h0;
        rd_reg(4'h7, d);
        check("event flags", d, 16'h0007);
        // Full pulse length, second jump in mid-pulse ignored
        wr_reg(4'h0, 16'h0001);
        pair(rows[0]);
        // Trip rose one edge before pair returned
        t0 = cyc - 1;
        fe.send('{BASE + 16'h1112, 16'h0000, 16'h01F4, 16'h0000, 16'h0000});
        while (trip === 1'h1 && cyc < t0 + 2000) begin
            @(posedge mclk);
            #1;
        end
        check("pulse cycles", 16'(cyc - t0), 16'(150 * CYC));
        check("irq masked", irq, 16'h0000);
        wr_reg(4'h8, 16'h0007);
        repeat (2) @(posedge mclk);
        #1;
        check("irq", irq, 16'h0001);
        rd_reg(4'h7, d);
        check("event flags", d, 16'h0003);
        @(posedge mclk);
        #1;
        check("irq cleared", irq, 16'h0000);
        rd_reg(4'h7, d);
        check("event cleared", d, 16'h0000);
        // Reset in mid-run ends the pulse and restores settings
        wr_reg(4'h0, 16'h0001);
        pair(rows[0]);
        check("trip before reset", trip, 16'h0001);
        wr_reg(4'h1, 16'h0014);
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        #1;
        check("start after reset", start, 16'h0000);
        check("trip after reset", trip, 16'h0000);
        check("irq after reset", irq, 16'h0000);
        rd_reg(4'h1, d);
        check("phase limit reset", d, 16'h000A);
        // Clock enable low freezes the settings
        ce <= 1'h0;
        wr_reg(4'h1, 16'h0014);
        ce <= 1'h1;
        rd_reg(4'h1, d);
        check("frozen write", d, 16'h000A);
        report_and_stop();
    end
endmodule
